// [verilog/asp_consts.vh]
`ifndef ASP_CONSTS_VH
`define ASP_CONSTS_VH
// Result width and daisy-chain delay in serial clock periods
`define ASP_RESULT_BITS   16
`define ASP_CHAIN_DELAY   16
// Conversion time in ns and derived core cycles at 40 MHz
`define ASP_CONV_NS       1000
`define ASP_CLK_MHZ       40
`define ASP_CONV_CYCLES   ((`ASP_CONV_NS * `ASP_CLK_MHZ) / 1000)
// Base half period of internal serial clock in core cycles
`define ASP_SCLK_HALF     1
// Reset value of the result register
`define ASP_RESULT_RST    16'h0000
`endif

// [verilog/asp_port.v]
`timescale 1ns/100ps
// Functional notes
// R1: Select low drives shared pins as parallel bus
// R2: Master read-after-convert uses divide inputs for clock
// R3: Other serial modes float the divide pins
// R4: Master mode drives internal serial clock out
// R5: Slave shifts on host clock only with select
// R6: Frame marker polarity follows polarity select input
// R7: Clock invert applies in master and slave
// R8: Slave chains input level after sixteen clocks
// R9: Master read-during-convert shifts previous result
// R10: Master read-after-convert shifts after conversion ends
// R11: Result shifts out most significant bit first
// R12: Slave updates output on rising, inverted swaps
// R13: Slave unfinished read at completion pulses flag
// R14: Busy high from start until result latched
// R15: Host keeps mode inputs stable during sequences
`include "asp_consts.vh"
module asp_port
#(
  parameter W = `ASP_RESULT_BITS
)
(
  input  wire         CORE_CLK_IN,      // 40 MHz core clock
  input  wire         RESET_N_IN,       // Async reset, active low
  input  wire         PORT_TYPE_SELECT_IN, // High selects serial
  input  wire         CONVERT_START_IN, // Start pulse
  input  wire [W-1:0] CONV_DATA_IN,     // Result of conversion core
  input  wire         CS_N_IN,          // Chip select, active low
  input  wire [1:0]   CLOCK_DIVIDE_SELECT_IN, // Pin inputs
  input  wire         CLOCK_SOURCE_SELECT_IN, // High is slave
  input  wire         FRAME_MARKER_POLARITY_IN, // High: active low
  input  wire         CLOCK_INVERT_SELECT_IN, // Inverts clock sense
  input  wire         READMODE_OR_CHAIN_INPUT_IN, // Mode or chain in
  input  wire         SCLK_IN,          // Host serial clock pin in
  output wire         SCLK_OUT,         // Serial clock pin out
  output wire         SCLK_OE_N_OUT,    // Low while driving clock
  output wire         DIV_OE_N_OUT,     // Divide pins enable, low drives
  output reg  [W-1:0] PAR_DATA_OUT,     // Parallel bus
  output wire         PAR_OE_N_OUT,     // Low while bus driven
  output reg          SERIAL_RESULT_OUT, // Serial data
  output wire         FRAME_MARKER_OUT, // Frame marker
  output reg          INCOMPLETE_READ_FLAG_OUT, // One-cycle pulse
  output reg          BUSY_OUT,         // Conversion in progress
  output wire         READY_OUT         // Buffer can take a result
);

  localparam ST_IDLE  = 2'b00;
  localparam ST_SHIFT = 2'b01;
  localparam CW = 12;
  // Integer constants cut on purpose to the counters they meet
  localparam integer  CONV_N    = `ASP_CONV_CYCLES;
  localparam integer  CHAIN_N   = `ASP_CHAIN_DELAY;
  localparam integer  WORD_N    = W;
  localparam [CW-1:0] CONV_LOAD = CONV_N[CW-1:0];
  localparam [CW-1:0] CNT_ONE   = {{(CW-1){1'b0}}, 1'b1};
  localparam [4:0]    CHAIN_DLY = CHAIN_N[4:0];
  localparam [4:0]    WORD_BITS = WORD_N[4:0];

  wire serial = PORT_TYPE_SELECT_IN;
  wire slave  = serial & CLOCK_SOURCE_SELECT_IN;
  wire master = serial & ~CLOCK_SOURCE_SELECT_IN;
  wire rd_during = master & READMODE_OR_CHAIN_INPUT_IN;
  wire rd_after  = master & ~READMODE_OR_CHAIN_INPUT_IN;

  // Two-entry result buffer between converter and output port
  reg [W-1:0] buf_data [0:1];
  reg [1:0]   buf_cnt;
  reg         buf_rd_ptr;
  reg         buf_wr_ptr;
  wire        buf_valid = (buf_cnt != 2'd0);
  wire        buf_ready = (buf_cnt != 2'd2);
  reg         take;
  assign READY_OUT = buf_ready;

  // Conversion timer and busy
  reg [CW-1:0] conv_cnt;
  reg          conv_done;
  always @(posedge CORE_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      conv_cnt  <= {CW{1'b0}};
      BUSY_OUT  <= 1'b0;
      conv_done <= 1'b0;
    end
    else
    begin
      conv_done <= 1'b0;
      if (CONVERT_START_IN && !BUSY_OUT)
      begin
        BUSY_OUT <= 1'b1; // R14
        conv_cnt <= CONV_LOAD;
      end
      else if (BUSY_OUT && conv_cnt > CNT_ONE)
        conv_cnt <= conv_cnt - CNT_ONE;
      // Busy stays up while a full buffer stalls the latch
      else if (BUSY_OUT && buf_ready)
      begin
        BUSY_OUT  <= 1'b0; // R14
        conv_done <= 1'b1;
      end
    end
  end

  // Buffer write on completion, read when shifter or parallel bus takes a word
  always @(posedge CORE_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      buf_cnt    <= 2'd0;
      buf_rd_ptr <= 1'b0;
      buf_wr_ptr <= 1'b0;
      buf_data[0] <= `ASP_RESULT_RST;
      buf_data[1] <= `ASP_RESULT_RST;
    end
    else
    begin
      if (conv_done)
      begin
        buf_data[buf_wr_ptr] <= CONV_DATA_IN;
        buf_wr_ptr <= ~buf_wr_ptr;
      end
      if (take)
        buf_rd_ptr <= ~buf_rd_ptr;
      buf_cnt <= buf_cnt + {1'b0, conv_done} - {1'b0, take};
    end
  end

  // Internal serial clock, slowed by the divide inputs in read-after-convert only
  reg [5:0] div_cnt;
  reg       int_sclk;
  wire [5:0] half = rd_after ? // R2
    (6'd1 << CLOCK_DIVIDE_SELECT_IN) : 6'd1;
  wire int_rise = (div_cnt + 6'd1 >= half) & ~int_sclk;

  // Host clock edge detect, sampled as synchronous
  reg sclk_q;
  wire sclk_n = SCLK_IN ^ CLOCK_INVERT_SELECT_IN; // R7
  wire ext_upd = slave & ~CS_N_IN & sclk_n & ~sclk_q; // R5 R12

  reg [W-1:0] shreg;
  reg [4:0]   bits;
  reg [1:0]   state;
  reg         chain_q;
  reg [W-1:0] par_q;
  wire        shift_ev = slave ? ext_upd : int_rise;
  wire        word_end = ~slave & (bits == WORD_BITS) & ~int_sclk; // R4

  // Start condition for a word per mode
  reg start_ok;
  always @*
  begin
    start_ok = 1'b0;
    if (slave)
      start_ok = ~CS_N_IN;
    else if (rd_during)
      start_ok = BUSY_OUT; // R9
    else if (rd_after)
      start_ok = ~BUSY_OUT; // R10
    // Parallel mode pops each word onto the bus, so busy cannot hang
    take = buf_valid & (serial ? ((state == ST_IDLE) & start_ok) : 1'b1);
  end

  always @(posedge CORE_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      state    <= ST_IDLE;
      shreg    <= {W{1'b0}};
      bits     <= 5'd0;
      div_cnt  <= 6'd0;
      int_sclk <= 1'b0;
      sclk_q   <= 1'b0;
      chain_q  <= 1'b0;
      SERIAL_RESULT_OUT <= 1'b0;
      INCOMPLETE_READ_FLAG_OUT <= 1'b0;
      PAR_DATA_OUT <= `ASP_RESULT_RST;
    end
    else
    begin
      sclk_q <= sclk_n;
      INCOMPLETE_READ_FLAG_OUT <= 1'b0;
      if (!serial && take)
        PAR_DATA_OUT <= buf_data[buf_rd_ptr]; // R1
      if (state == ST_SHIFT && !slave && !word_end)
      begin
        div_cnt <= (div_cnt + 6'd1 >= half) ? 6'd0 : div_cnt + 6'd1;
        if (div_cnt + 6'd1 >= half)
          int_sclk <= ~int_sclk; // R4
      end
      else
      begin
        div_cnt  <= 6'd0;
        int_sclk <= 1'b0;
      end
      case (state)
        ST_IDLE:
        begin
          if (take && serial)
          begin
            shreg <= buf_data[buf_rd_ptr];
            bits  <= 5'd0;
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (slave && conv_done)
          begin
            state <= ST_IDLE; // R13
            INCOMPLETE_READ_FLAG_OUT <= 1'b1; // R13
          end
          // Marker stays up until the last bit's falling clock edge
          else if (word_end)
            state <= ST_IDLE; // R4
          else if (shift_ev)
          begin
            if (bits < CHAIN_DLY)
              SERIAL_RESULT_OUT <= shreg[W-1]; // R11
            else
              SERIAL_RESULT_OUT <= chain_q; // R8
            shreg   <= {shreg[W-2:0], 1'b0};
            chain_q <= READMODE_OR_CHAIN_INPUT_IN;
            bits    <= bits + 5'd1;
          end
          if (slave && CS_N_IN)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  wire active = (state == ST_SHIFT);
  assign SCLK_OUT = int_sclk ^ CLOCK_INVERT_SELECT_IN; // R7
  assign SCLK_OE_N_OUT = ~master; // R4
  assign DIV_OE_N_OUT  = 1'b1; // R3
  assign PAR_OE_N_OUT  = serial; // R1
  assign FRAME_MARKER_OUT = active ^ FRAME_MARKER_POLARITY_IN; // R6
endmodule // asp_port

// [verification/asp_port_assertions.sv]
`timescale 1ns/100ps
module asp_port_chk
(
  input logic CORE_CLK_IN,              // Clock
  input logic RESET_N_IN,               // Reset
  input logic PORT_TYPE_SELECT_IN,      // Serial
  input logic CONVERT_START_IN,         // Start
  input logic CLOCK_SOURCE_SELECT_IN,   // Slave
  input logic FRAME_MARKER_POLARITY_IN, // Polarity
  input logic SCLK_OE_N_OUT,            // Clock enable
  input logic DIV_OE_N_OUT,             // Divide enable
  input logic PAR_OE_N_OUT,             // Bus enable
  input logic FRAME_MARKER_OUT,         // Marker
  input logic INCOMPLETE_READ_FLAG_OUT, // Flag
  input logic BUSY_OUT                  // Busy
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  a_par_select: assert property (PAR_OE_N_OUT == PORT_TYPE_SELECT_IN)
    else $error("bus enable wrong");
  a_div_floated: assert property (DIV_OE_N_OUT)
    else $error("divide pins driven");
  a_clk_master: assert property
    (SCLK_OE_N_OUT != (PORT_TYPE_SELECT_IN && !CLOCK_SOURCE_SELECT_IN))
    else $error("clock enable wrong");
  a_marker_serial: assert property
    (FRAME_MARKER_OUT != FRAME_MARKER_POLARITY_IN |-> PORT_TYPE_SELECT_IN)
    else $error("marker active");
  a_flag_single: assert property
    (INCOMPLETE_READ_FLAG_OUT |=> !INCOMPLETE_READ_FLAG_OUT)
    else $error("flag too long");
  a_flag_slave: assert property (INCOMPLETE_READ_FLAG_OUT |->
    PORT_TYPE_SELECT_IN && CLOCK_SOURCE_SELECT_IN) else $error("flag mode");
  a_busy_start: assert property (CONVERT_START_IN && !BUSY_OUT |=> BUSY_OUT)
    else $error("busy late");
  a_busy_hold: assert property ($rose(BUSY_OUT) |->
    BUSY_OUT[*8] ##30 BUSY_OUT) else $error("busy short");
  // Main scenarios reached
  cover property ($fell(BUSY_OUT));
  cover property (INCOMPLETE_READ_FLAG_OUT);
  cover property (FRAME_MARKER_OUT != FRAME_MARKER_POLARITY_IN);
endmodule // asp_port_chk
bind asp_port asp_port_chk i_chk (.*);

// [verification/asp_host.sv]
`timescale 1ns/100ps
module asp_host
(
  input  logic clk,  // Core clock
  input  logic inv,  // Clock sense
  input  logic sdo,  // Device data
  output logic sclk, // Host clock
  output logic cs_n  // Chip select
);
  initial cs_n = 1'h1;
  initial sclk = 1'h0;
  // Slow clock, still outside frames, so core sync never misses an edge
  task automatic rd(input int n, output logic [31:0] w);
    sclk <= inv;
    cs_n <= 1'h0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      sclk <= ~inv;
      repeat (4) @(posedge clk);
      w = {w[30:0], sdo};
      sclk <= inv;
      repeat (4) @(posedge clk);
    end
    cs_n <= 1'h1;
  endtask
endmodule // asp_host

// [verification/test_asp_port.sv]
`timescale 1ns/100ps
module test_asp_port;
  logic CORE_CLK_IN = 0, RESET_N_IN = 0, PORT_TYPE_SELECT_IN = 0;
  logic CONVERT_START_IN = 0, CLOCK_SOURCE_SELECT_IN = 0, CS_N_IN;
  logic FRAME_MARKER_POLARITY_IN = 1, CLOCK_INVERT_SELECT_IN = 0;
  logic READMODE_OR_CHAIN_INPUT_IN = 0, SCLK_IN, SCLK_OUT, BUSY_OUT;
  logic [1:0] CLOCK_DIVIDE_SELECT_IN = 1;
  logic [15:0] CONV_DATA_IN = 0, PAR_DATA_OUT, cap;
  logic SCLK_OE_N_OUT, DIV_OE_N_OUT, PAR_OE_N_OUT, SERIAL_RESULT_OUT;
  logic FRAME_MARKER_OUT, INCOMPLETE_READ_FLAG_OUT, READY_OUT, sq, bz;
  logic [31:0] w;
  int n_mismatch, n_checks, cyc, n_flag, k;
  asp_port i_dut (.*);
  asp_host i_host (.clk(CORE_CLK_IN), .inv(CLOCK_INVERT_SELECT_IN),
    .sdo(SERIAL_RESULT_OUT), .sclk(SCLK_IN), .cs_n(CS_N_IN));
  always #12.5 CORE_CLK_IN = ~CORE_CLK_IN;
  // Master capture at internal clock fall, flag count, hang guard
  always @(posedge CORE_CLK_IN)
  begin
    if (!SCLK_OE_N_OUT && sq && !SCLK_OUT && FRAME_MARKER_OUT == 1'h0)
    begin
      cap <= {cap[14:0], SERIAL_RESULT_OUT};
      bz <= BUSY_OUT;
    end
    sq <= SCLK_OUT;
    n_flag <= n_flag + INCOMPLETE_READ_FLAG_OUT;
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_mismatch++;
      summarize;
    end
  end
  task chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task rst(input logic p, s, r);
    RESET_N_IN <= 1'h0;
    PORT_TYPE_SELECT_IN <= p;
    CLOCK_SOURCE_SELECT_IN <= s;
    CLOCK_INVERT_SELECT_IN <= s;
    READMODE_OR_CHAIN_INPUT_IN <= r;
    repeat (20) @(posedge CORE_CLK_IN);
    RESET_N_IN <= 1'h1;
  endtask
  // Conversion of 40 cycles plus margin
  task go(input logic [15:0] d);
    @(posedge CORE_CLK_IN);
    CONV_DATA_IN <= d;
    CONVERT_START_IN <= 1'h1;
    @(posedge CORE_CLK_IN);
    CONVERT_START_IN <= 1'h0;
    repeat (45) @(posedge CORE_CLK_IN);
  endtask
  task t_par;
    rst(0, 0, 0);
    go(16'h8e5b);
    chk(PAR_DATA_OUT, 16'h8e5b);
    chk(PAR_OE_N_OUT, 1'h0);
  endtask
  task t_after;
    rst(1, 0, 0);
    go(16'hb38d);
    repeat (80) @(posedge CORE_CLK_IN);
    chk(cap, 16'hb38d);
    chk(bz, 1'h0);
  endtask
  task t_during;
    rst(1, 0, 1);
    go(16'h6e21);
    go(16'h19f4);
    chk(cap, 16'h6e21);
    chk(bz, 1'h1);
  endtask
  // Inverted host clock, full buffer, oldest word then chain level
  task t_slave;
    rst(1, 1, 1);
    go(16'hc5a7);
    go(16'h3b1e);
    chk(READY_OUT, 1'h0);
    i_host.rd(17, w);
    chk(w[16:0], {16'hc5a7, 1'h1});
  endtask
  // Conversion ends while a read is still running
  task t_abort;
    rst(1, 1, 0);
    go(16'h0ff0);
    k = n_flag;
    fork
      go(16'h7331);
      i_host.rd(8, w);
    join
    chk(n_flag - k, 1);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    t_par;
    t_after;
    t_during;
    t_slave;
    t_abort;
    summarize;
  end
endmodule // test_asp_port
